// File: mbp_pkg.sv
package mbp_pkg;

  // Host bus configurations
  typedef enum logic [2:0] {
    MBP_CFG_STD   = 3'b000,
    MBP_CFG_ONE   = 3'b001,
    MBP_CFG_PAGE1 = 3'b010,
    MBP_CFG_PAGE2 = 3'b011,
    MBP_CFG_BURST = 3'b100,
    MBP_CFG_DSRW  = 3'b101
  } mbp_cfg_t;

  // Port output multiplexer selects
  typedef enum logic [1:0] {
    MBP_OSEL_DATA = 2'b00,
    MBP_OSEL_ADDR = 2'b01,
    MBP_OSEL_MCEL = 2'b10,
    MBP_OSEL_CS   = 2'b11
  } mbp_osel_t;

  // Readback sources
  typedef enum logic [2:0] {
    MBP_RB_DOUT = 3'b000,
    MBP_RB_MCEL = 3'b001,
    MBP_RB_DIR  = 3'b010,
    MBP_RB_CTRL = 3'b011,
    MBP_RB_PIN  = 3'b100,
    MBP_RB_IMC  = 3'b101
  } mbp_rbsel_t;

  // Input macrocell modes
  typedef enum logic [1:0] {
    MBP_IMC_DIRECT = 2'b00,
    MBP_IMC_LATCH  = 2'b01,
    MBP_IMC_REG    = 2'b10
  } mbp_imc_t;

  localparam int unsigned MBP_PORT_W   = 8;
  localparam int unsigned MBP_PORTD_W  = 3;
  localparam int unsigned MBP_NPORTS   = 4;
  localparam int unsigned MBP_ADDR_W   = 20;
  localparam logic [7:0]  MBP_DIR_RST  = 8'h00;
  localparam logic [7:0]  MBP_DOUT_RST = 8'h00;
  localparam logic [7:0]  MBP_CTRL_RST = 8'h00;
  localparam logic [19:0] MBP_ADDR_RST = 20'h00000;

  // Host strobes after configuration mapping
  typedef struct packed {
    logic wrStb;
    logic rdStb;
    logic psStb;
  } mbp_strobe_t;

endpackage

// File: mbp_port_pin.sv
module mbp_port_pin
  import mbp_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Per-pin configuration
  input  wire mbp_pkg::mbp_osel_t  outSel,
  input  wire mbp_pkg::mbp_imc_t   imcMode,
  input  wire logic                imcUseTerm,
  // Sources
  input  wire logic                dataOut,
  input  wire logic                addrBit,
  input  wire logic                mcelOut,
  input  wire logic                chipSel,
  input  wire logic                dirBit,
  input  wire logic                oeTerm,
  input  wire logic                imcTerm,
  input  wire logic                aleEdge,
  input  wire logic                pinIn,
  // Results
  output logic                     pinOut,
  output logic                     pinOeN,
  output logic                     imcOut
);
  logic imcHold;
  logic imcStb;

  assign imcStb = imcUseTerm ? imcTerm : aleEdge;

  // Output multiplexer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinOut <= 1'b0;
    end else begin
      case (outSel)
        MBP_OSEL_DATA: pinOut <= dataOut;
        MBP_OSEL_ADDR: pinOut <= addrBit;
        MBP_OSEL_MCEL: pinOut <= mcelOut;
        default:       pinOut <= chipSel;
      endcase
    end
  end

  // Enable is OR of product term and direction; active low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinOeN <= 1'b1;
    end else begin
      pinOeN <= ~(oeTerm | dirBit);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      imcHold <= 1'b0;
    end else if (imcStb) begin
      imcHold <= pinIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      imcOut <= 1'b0;
    end else begin
      case (imcMode)
        MBP_IMC_LATCH: imcOut <= imcStb ? pinIn : imcHold;
        MBP_IMC_REG:   imcOut <= imcHold;
        default:       imcOut <= pinIn;
      endcase
    end
  end
endmodule

// File: mbp_strobe_map.sv
module mbp_strobe_map
  import mbp_pkg::*;
(
  // Configuration
  input  wire mbp_pkg::mbp_cfg_t    busCfg,
  // Control inputs
  input  wire logic                 control_input_0,
  input  wire logic                 control_input_1,
  input  wire logic                 control_input_2,
  // Mapped strobes
  output mbp_pkg::mbp_strobe_t      stb
);
  always_comb begin
    stb = '{wrStb: 1'b0, rdStb: 1'b0, psStb: 1'b0};
    case (busCfg)
      MBP_CFG_PAGE1, MBP_CFG_PAGE2: begin
        stb.wrStb = control_input_0;
        stb.psStb = control_input_1;
      end
      MBP_CFG_BURST: begin
        stb.wrStb = control_input_0;
        stb.rdStb = control_input_1;
        stb.psStb = control_input_2;
      end
      MBP_CFG_DSRW: begin
        // Control 0 is read/not-write, control 1 is data strobe
        stb.wrStb = control_input_1 & ~control_input_0;
        stb.rdStb = control_input_1 & control_input_0;
      end
      default: begin
        stb.wrStb = control_input_0;
        stb.rdStb = control_input_1;
        stb.psStb = control_input_2;
      end
    endcase
  end
endmodule

// File: mbp_bus_port.sv
module mbp_bus_port
  import mbp_pkg::*;
(
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // Static configuration
  input  wire mbp_pkg::mbp_cfg_t       busCfg,
  input  wire logic                    addr16OnPortA,
  input  wire logic [3:0][7:0]         imcModeFlat,
  input  wire logic [2:0]              imcUseTerm,
  input  wire logic [3:0][15:0]        outSelCfg,
  // Host bus
  input  wire logic                    addr_strobe_alt,
  input  wire logic                    high_byte_enable,
  input  wire logic                    control_input_0,
  input  wire logic                    control_input_1,
  input  wire logic                    control_input_2,
  input  wire logic [7:0]              adIn,
  input  wire logic [3:0]              lowAddrIn,
  output logic [7:0]                   adOut,
  output logic                         adOeN,
  // Resource select from decode logic
  input  wire logic                    resourceSel,
  // Port register access
  input  wire logic                    regWrite,
  input  wire logic [1:0]              regPort,
  input  wire logic [1:0]              regKind,
  input  wire logic [7:0]              regWdata,
  input  wire mbp_pkg::mbp_rbsel_t     rbSel,
  // Logic array signals
  input  wire logic [3:0][7:0]         mcelOut,
  input  wire logic [3:0][7:0]         chipSel,
  input  wire logic [3:0][7:0]         oeTerm,
  input  wire logic [2:0][1:0]         imcTerm,
  // Pins
  input  wire logic [3:0][7:0]         pinIn,
  output logic [3:0][7:0]              pinOut,
  output logic [3:0][7:0]              pinOeN,
  // Decoded outputs
  output logic [19:0]                  hostAddr,
  output logic                         oddByte,
  output mbp_pkg::mbp_strobe_t         hostStb,
  output logic [2:0][7:0]              imcBus,
  output logic [7:0]                   readback
);
  import mbp_pkg::*;

  logic [3:0][7:0]    dataOutReg;
  logic [3:0][7:0]    dirReg;
  logic [1:0][7:0]    ctrlReg;
  logic [19:0]        latAddr;
  logic               aleDly;
  logic               aleEdge;
  mbp_strobe_t        stbNow;
  logic [3:0][7:0]    pinOutW;
  logic [3:0][7:0]    pinOeW;
  logic [3:0][7:0]    imcW;
  logic [3:0][7:0]    portMask;
  logic [19:0]        next_addr;

  assign aleEdge = addr_strobe_alt & ~aleDly;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aleDly <= 1'b0;
    end else begin
      aleDly <= addr_strobe_alt;
    end
  end

  mbp_strobe_map u_map (
    .busCfg          (busCfg),
    .control_input_0 (control_input_0),
    .control_input_1 (control_input_1),
    .control_input_2 (control_input_2),
    .stb             (stbNow)
  );

  // Address latch per bus style
  always_ff @(posedge core_clk) begin
    if (rst) begin
      latAddr <= MBP_ADDR_RST;
    end else if (aleEdge) begin
      case (busCfg)
        // MBP_CFG_PAGE2 is a page bus and latches the high byte; its low byte is tracked live below
        MBP_CFG_PAGE2: latAddr[15:8] <= adIn;
        MBP_CFG_BURST: latAddr[11:4] <= adIn;
        default:       latAddr[7:0]  <= adIn;
      endcase
    end
  end

  // Upper bits held between strobes except address 16 when addr16OnPortA; low lines tracked live for MBP_CFG_PAGE2 and MBP_CFG_BURST only
  always_comb begin
    next_addr = latAddr;
    case (busCfg)
      MBP_CFG_PAGE2: next_addr[7:0] = adIn;
      MBP_CFG_BURST: next_addr[3:0] = lowAddrIn;
      default: next_addr = latAddr;
    endcase
    if (addr16OnPortA) begin
      next_addr[16] = pinIn[0][0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hostAddr <= MBP_ADDR_RST;
      oddByte  <= 1'b0;
    end else begin
      hostAddr <= next_addr;
      oddByte  <= next_addr[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hostStb <= '{wrStb: 1'b0, rdStb: 1'b0, psStb: 1'b0};
    end else begin
      hostStb <= stbNow;
    end
  end

  // Port registers written by the host
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dataOutReg <= {4{MBP_DOUT_RST}};
      dirReg     <= {4{MBP_DIR_RST}};
      ctrlReg    <= {2{MBP_CTRL_RST}};
    end else if (regWrite) begin
      case (regKind)
        2'h0: dataOutReg[regPort] <= regWdata & portMask[regPort];
        2'h1: dirReg[regPort]     <= regWdata & portMask[regPort];
        2'h2: begin
          if (regPort < 2'h2) begin
            ctrlReg[regPort[0]] <= regWdata;
          end
        end
        default: ;
      endcase
    end
  end

  assign portMask = {8'h07, 8'hff, 8'hff, 8'hff};

  // Pin slices
  genvar gp;
  genvar gb;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_port
      for (gb = 0; gb < 8; gb++) begin : g_bit
        if (gp < 3 || gb < MBP_PORTD_W) begin : g_pin
          mbp_osel_t selW;
          always_comb begin
            selW = mbp_osel_t'(outSelCfg[gp][2*gb +: 2]);
            // Control register forces address out on ports A and B
            if (gp < 2 && ctrlReg[gp][gb]) begin
              selW = MBP_OSEL_ADDR;
            end
          end
          mbp_port_pin u_pin (
            .core_clk   (core_clk),
            .rst        (rst),
            .outSel     (selW),
            .imcMode    (mbp_imc_t'(imcModeFlat[gp][2*(gb%4) +: 2])),
            .imcUseTerm ((gp < 3) ? imcUseTerm[gp % 3] : 1'b0),
            .dataOut    (dataOutReg[gp][gb]),
            .addrBit    (latAddr[gb]),
            .mcelOut    (mcelOut[gp][gb]),
            .chipSel    (chipSel[gp][gb]),
            .dirBit     (dirReg[gp][gb]),
            .oeTerm     (oeTerm[gp][gb]),
            .imcTerm    ((gp < 3) ? imcTerm[gp % 3][gb / 4] : 1'b0),
            .aleEdge    (aleEdge),
            .pinIn      (pinIn[gp][gb]),
            .pinOut     (pinOutW[gp][gb]),
            .pinOeN     (pinOeW[gp][gb]),
            .imcOut     (imcW[gp][gb])
          );
        end else begin : g_none
          assign pinOutW[gp][gb] = 1'b0;
          assign pinOeW[gp][gb]  = 1'b1;
          assign imcW[gp][gb]    = 1'b0;
        end
      end
    end
  endgenerate

  assign pinOut = pinOutW;
  assign pinOeN = pinOeW;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      imcBus <= '0;
    end else begin
      imcBus <= {imcW[2], imcW[1], imcW[0]};
    end
  end

  // Readback buffer: one source at a time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      readback <= 8'h00;
    end else begin
      case (rbSel)
        MBP_RB_DOUT: readback <= dataOutReg[regPort];
        MBP_RB_MCEL: readback <= mcelOut[regPort] & portMask[regPort];
        MBP_RB_DIR:  readback <= dirReg[regPort];
        MBP_RB_CTRL: readback <= (regPort < 2'h2) ? ctrlReg[regPort[0]] : 8'h00;
        MBP_RB_PIN:  readback <= pinIn[regPort] & portMask[regPort];
        MBP_RB_IMC:  readback <= (regPort < 2'h3) ? imcW[regPort] : 8'h00;
        default:     readback <= 8'h00;
      endcase
    end
  end

  // Shared lines driven only during a selected read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      adOut <= 8'h00;
      adOeN <= 1'b1;
    end else begin
      adOut <= readback;
      adOeN <= ~(resourceSel & (stbNow.rdStb | stbNow.psStb));
    end
  end

  // Assertions
  rd_drive_a: assert property (@(posedge core_clk) disable iff (rst)
    !adOeN |-> $past(resourceSel)) else $error("data lines driven without select");
  dir_reset_a: assert property (@(posedge core_clk)
    $past(rst) |-> dirReg == '0) else $error("direction not cleared");
  odd_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    oddByte == hostAddr[0]) else $error("byte lane mismatch");
  sequence s_pagehit;
    busCfg == MBP_CFG_PAGE2 && !aleEdge;
  endsequence
  page_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    s_pagehit |=> $stable(latAddr[15:8])) else $error("page byte lost");
  burst_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    busCfg == MBP_CFG_BURST && !aleEdge |=> $stable(latAddr[19:4]))
    else $error("burst upper address moved");
  oe_or_a: assert property (@(posedge core_clk) disable iff (rst)
    dirReg[1][2] |=> !pinOeN[1][2]) else $error("direction did not enable pin");
  portd_a: assert property (@(posedge core_clk) disable iff (rst)
    dirReg[3][7:3] == 5'h00) else $error("port D upper bits set");
  cfg4_a: assert property (@(posedge core_clk) disable iff (rst)
    busCfg == MBP_CFG_BURST && control_input_2 |=> hostStb.psStb)
    else $error("program-store strobe missing");

  // Address capture per bus style
  sequence s_std_ale;
    aleEdge && busCfg != MBP_CFG_PAGE2 && busCfg != MBP_CFG_BURST;
  endsequence
  sequence s_page_ale;
    aleEdge && busCfg == MBP_CFG_PAGE2;
  endsequence
  sequence s_burst_ale;
    aleEdge && busCfg == MBP_CFG_BURST;
  endsequence
  std_latch_a: assert property (@(posedge core_clk) disable iff (rst)
    s_std_ale |=> latAddr[7:0] == $past(adIn)) else $error("low address not latched");
  page_latch_a: assert property (@(posedge core_clk) disable iff (rst)
    s_page_ale |=> latAddr[15:8] == $past(adIn)) else $error("page byte not latched");
  burst_latch_a: assert property (@(posedge core_clk) disable iff (rst)
    s_burst_ale |=> latAddr[11:4] == $past(adIn)) else $error("burst byte not latched");

  // Live address lines: low bits and address 16
  page_low_a: assert property (@(posedge core_clk) disable iff (rst)
    busCfg == MBP_CFG_PAGE2 |=> hostAddr[7:0] == $past(adIn))
    else $error("page low byte not live");
  burst_low_a: assert property (@(posedge core_clk) disable iff (rst)
    busCfg == MBP_CFG_BURST |=> hostAddr[3:0] == $past(lowAddrIn)
      && hostAddr[15:4] == $past(latAddr[15:4])) else $error("burst address wrong");
  addr_high_a: assert property (@(posedge core_clk) disable iff (rst)
    addr16OnPortA |=> hostAddr[16] == $past(pinIn[0][0])) else $error("address 16 wrong");

  // Strobe mapping
  sequence s_page_cfg;
    busCfg == MBP_CFG_PAGE1 || busCfg == MBP_CFG_PAGE2;
  endsequence
  sequence s_ds_write;
    busCfg == MBP_CFG_DSRW && control_input_1 && !control_input_0;
  endsequence
  sequence s_ds_read;
    busCfg == MBP_CFG_DSRW && control_input_1 && control_input_0;
  endsequence
  page_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
    s_page_cfg |=> !hostStb.rdStb && hostStb.psStb == $past(control_input_1))
    else $error("page strobe mapping wrong");
  ds_write_a: assert property (@(posedge core_clk) disable iff (rst)
    s_ds_write |=> hostStb.wrStb && !hostStb.rdStb) else $error("derived write missing");
  ds_read_a: assert property (@(posedge core_clk) disable iff (rst)
    s_ds_read |=> hostStb.rdStb && !hostStb.wrStb) else $error("derived read missing");

  // Data line enable and port paths
  sequence s_sel_read;
    resourceSel && (stbNow.rdStb || stbNow.psStb);
  endsequence
  rd_enable_a: assert property (@(posedge core_clk) disable iff (rst)
    s_sel_read |=> !adOeN) else $error("selected read not driven");
  ad_follow_a: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> adOut == $past(readback))
    else $error("data lines do not follow readback");
  oe_all_a: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> pinOeN[2:0] == ~$past(oeTerm[2:0] | dirReg[2:0])
      && pinOeN[3][2:0] == ~$past(oeTerm[3][2:0] | dirReg[3][2:0]))
    else $error("pin enable not OR of term and direction");
  portd_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    pinOeN[3][7:3] == 5'h1f && pinOut[3][7:3] == 5'h00)
    else $error("port D spare bits active");
  ctrl_force_a: assert property (@(posedge core_clk) disable iff (rst)
    ctrlReg[0] == 8'hff |=> pinOut[0] == $past(latAddr[7:0]))
    else $error("address out missing");
  rb_dout_a: assert property (@(posedge core_clk) disable iff (rst)
    rbSel == MBP_RB_DOUT |=> readback == $past(dataOutReg[regPort]))
    else $error("readback not data out");
  rb_dir_a: assert property (@(posedge core_clk) disable iff (rst)
    rbSel == MBP_RB_DIR |=> readback == $past(dirReg[regPort]))
    else $error("readback not direction");
  rb_ctrl_a: assert property (@(posedge core_clk) disable iff (rst)
    rbSel == MBP_RB_CTRL && regPort < 2'h2 |=> readback == $past(ctrlReg[regPort[0]]))
    else $error("readback not control");
  rb_pin_a: assert property (@(posedge core_clk) disable iff (rst)
    rbSel == MBP_RB_PIN |=> readback == $past(pinIn[regPort] & portMask[regPort]))
    else $error("readback not pins");
  imc_bus_a: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> imcBus == $past({imcW[2], imcW[1], imcW[0]}))
    else $error("macrocell bus stale");
endmodule

// File: mbp_host_model.sv
module mbp_host_model (
  // Clock
  input  wire logic       core_clk,
  // Host bus
  output logic            addr_strobe_alt,
  output logic            high_byte_enable,
  output logic [2:0]      ctrl,
  output logic [7:0]      adIn,
  output logic [3:0]      lowAddrIn
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_strobe_alt = 1'b0;
    high_byte_enable = 1'b0;
    ctrl = 3'h0;
    adIn = 8'h00;
    lowAddrIn = 4'h0;
  end

  // Full cycle: address out, strobe, then drive the complement of the address on the shared lines
  task automatic addrCycle(input logic [7:0] a, input logic hbe);
    @(negedge core_clk);
    adIn = a;
    high_byte_enable = hbe;
    addr_strobe_alt = 1'b1;
    repeat (2) @(negedge core_clk);
    addr_strobe_alt = 1'b0;
    @(negedge core_clk);
    adIn = ~a;
  endtask

  // Strobe-less cycle: the shared lines and the low address lines move, no strobe
  task automatic lowCycle(input logic [7:0] a, input logic [3:0] lo);
    @(negedge core_clk);
    adIn = a;
    lowAddrIn = lo;
  endtask

  task automatic setCtrl(input logic [2:0] c);
    @(negedge core_clk);
    ctrl = c;
  endtask
endmodule

// File: mbp_bus_port_test.sv
module mbp_bus_port_test;
  import mbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                core_clk, rst, addr16OnPortA, regWrite, resourceSel, adOeN, oddByte;
  logic                addr_strobe_alt, high_byte_enable;
  mbp_cfg_t            busCfg;
  mbp_rbsel_t          rbSel;
  mbp_strobe_t         hostStb;
  logic [3:0][7:0]     imcModeFlat, mcelOut, chipSel, oeTerm, pinIn, pinOut, pinOeN;
  logic [3:0][15:0]    outSelCfg;
  logic [2:0]          imcUseTerm, ctrl;
  logic [2:0][1:0]     imcTerm;
  logic [1:0]          regPort, regKind;
  logic [7:0]          regWdata, adIn, adOut, readback;
  logic [3:0]          lowAddrIn;
  logic [19:0]         hostAddr;
  logic [2:0][7:0]     imcBus;
  int                  numErrors, compares;

  mbp_host_model u_host (.core_clk, .addr_strobe_alt, .high_byte_enable, .ctrl, .adIn,
    .lowAddrIn);

  mbp_bus_port u_dut (
    .core_clk, .rst, .busCfg, .addr16OnPortA, .imcModeFlat, .imcUseTerm, .outSelCfg,
    .addr_strobe_alt, .high_byte_enable, .control_input_0(ctrl[0]),
    .control_input_1(ctrl[1]), .control_input_2(ctrl[2]), .adIn, .lowAddrIn, .adOut,
    .adOeN, .resourceSel, .regWrite, .regPort, .regKind, .regWdata, .rbSel, .mcelOut,
    .chipSel, .oeTerm, .imcTerm, .pinIn, .pinOut, .pinOeN, .hostAddr, .oddByte,
    .hostStb, .imcBus, .readback);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic st(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      numErrors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic regWr(input logic [1:0] p, input logic [1:0] k, input logic [7:0] d);
    @(negedge core_clk);
    regWrite = 1'b1;
    regPort = p;
    regKind = k;
    regWdata = d;
    @(negedge core_clk);
    regWrite = 1'b0;
  endtask

  task automatic testReset();
    rst = 1'b1;
    st(10);
    rst = 1'b0;
    st(1);
    chk("pinOeN", {pinOeN[2:0], pinOeN[3][2:0]}, 27'h7ffffff);
    chk("adOeN", adOeN, 1'b1);
  endtask

  task automatic testAddr();
    busCfg = MBP_CFG_STD;
    for (int i = 0; i < 2; i++) begin
      u_host.addrCycle(i ? 8'ha5 : 8'h5a, ~i[0]);
      st(3);
      chk("addrLow", hostAddr[7:0], i ? 8'ha5 : 8'h5a);
      chk("oddByte", oddByte, i[0]);
    end
    busCfg = MBP_CFG_PAGE2;
    u_host.addrCycle(8'h3c, 1'b0);
    u_host.lowCycle(8'h81, 4'h0);
    st(3);
    chk("pageAddr", hostAddr[15:0], 16'h3c81);
    u_host.lowCycle(8'h42, 4'h0);
    st(3);
    chk("pageHit", hostAddr[15:0], 16'h3c42);
    busCfg = MBP_CFG_BURST;
    u_host.addrCycle(8'h9e, 1'b0);
    for (int i = 0; i < 16; i++) begin
      u_host.lowCycle(8'h00, i[3:0]);
      st(2);
      chk("burstAddr", hostAddr[11:0], {8'h9e, i[3:0]});
    end
    addr16OnPortA = 1'b1;
    for (int i = 1; i >= 0; i--) begin
      pinIn[0][0] = i[0];
      st(3);
      chk("addr16", hostAddr[16], i[0]);
    end
    addr16OnPortA = 1'b0;
  endtask

  task automatic testStrobes();
    mbp_cfg_t   cfgs[6] = '{MBP_CFG_STD, MBP_CFG_ONE, MBP_CFG_PAGE1, MBP_CFG_PAGE2,
                            MBP_CFG_BURST, MBP_CFG_DSRW};
    logic [2:0] e;
    logic [2:0] m;
    for (int i = 0; i < 6; i++) begin
      busCfg = cfgs[i];
      for (int c = 0; c < 8; c++) begin
        u_host.setCtrl(c[2:0]);
        st(3);
        e = {c[0], c[1], c[2]};
        m = 3'h7;
        if (i == 2 || i == 3) begin
          e = {c[0], 1'b0, c[1]};
          m = 3'h7;
        end
        if (i == 5) begin
          e = {c[1] & ~c[0], c[1] & c[0], 1'b0};
          m = 3'h7;
        end
        chk("hostStb", hostStb & m, e & m);
      end
    end
    u_host.setCtrl(3'h0);
    busCfg = MBP_CFG_STD;
  endtask

  task automatic testPorts();
    mbp_rbsel_t srcs[4] = '{MBP_RB_DOUT, MBP_RB_MCEL, MBP_RB_DIR, MBP_RB_PIN};
    logic [7:0] rbv[4] = '{8'hc3, 8'h6d, 8'h0f, 8'h17};
    regWr(2'h1, 2'h1, 8'h0f);
    rbSel = MBP_RB_DIR;
    st(3);
    chk("pinOeN", pinOeN[1], 8'hf0);
    oeTerm[1] = 8'h30;
    st(3);
    chk("pinOeN", pinOeN[1], 8'hc0);
    oeTerm[1] = 8'h00;
    regWr(2'h3, 2'h1, 8'hff);
    st(3);
    chk("dirPortD", readback, 8'h07);
    regWr(2'h1, 2'h0, 8'hc3);
    mcelOut[1] = 8'h6d;
    chipSel[1] = 8'hb2;
    pinIn[1] = 8'h17;
    for (int i = 0; i < 4; i++) begin
      rbSel = srcs[i];
      st(3);
      chk("readback", readback, rbv[i]);
    end
    chk("pinData", pinOut[1], 8'hc3);
    outSelCfg[1] = 16'haaaa;
    st(3);
    chk("pinMcel", pinOut[1], 8'h6d);
    outSelCfg[1] = 16'hffff;
    st(3);
    chk("pinCs", pinOut[1], 8'hb2);
    u_host.addrCycle(8'h96, 1'b0);
    regWr(2'h0, 2'h2, 8'hff);
    regWr(2'h0, 2'h1, 8'hff);
    outSelCfg[0] = 16'h0000;
    rbSel = MBP_RB_CTRL;
    st(3);
    chk("pinAddr", pinOut[0], 8'h96);
    chk("pinOeN", pinOeN[0], 8'h00);
    chk("ctrlRead", readback, 8'hff);
    outSelCfg[1] = 16'h5555;
    st(3);
    chk("pinAddrB", pinOut[1], 8'h96);
  endtask

  task automatic testAd();
    regPort = 2'h1;
    rbSel = MBP_RB_DOUT;
    resourceSel = 1'b1;
    u_host.setCtrl(3'h2);
    st(4);
    chk("adOeN", adOeN, 1'b0);
    chk("adOut", adOut, 8'hc3);
    resourceSel = 1'b0;
    st(3);
    chk("adOeN", adOeN, 1'b1);
    resourceSel = 1'b1;
    u_host.setCtrl(3'h1);
    st(3);
    chk("adOeN", adOeN, 1'b1);
    resourceSel = 1'b0;
    u_host.setCtrl(3'h0);
  endtask

  task automatic testImc();
    pinIn[0] = 8'h3e;
    st(3);
    chk("imcDirect", imcBus[0], 8'h3e);
    imcModeFlat[0] = 8'haa;
    u_host.addrCycle(8'h00, 1'b0);
    pinIn[0] = 8'hc1;
    regPort = 2'h0;
    rbSel = MBP_RB_IMC;
    st(3);
    chk("imcReg", imcBus[0], 8'h3e);
    chk("imcRead", readback, 8'h3e);
    imcUseTerm[1] = 1'b1;
    imcModeFlat[1] = 8'haa;
    pinIn[1] = 8'h5b;
    imcTerm[1] = 2'h3;
    st(1);
    imcTerm[1] = 2'h0;
    pinIn[1] = 8'h00;
    st(3);
    chk("imcTerm", imcBus[1], 8'h5b);
    imcUseTerm[2] = 1'b1;
    imcModeFlat[2] = 8'h55;
    pinIn[2] = 8'ha7;
    imcTerm[2] = 2'h3;
    st(1);
    imcTerm[2] = 2'h0;
    pinIn[2] = 8'h00;
    st(3);
    chk("imcLatch", imcBus[2], 8'ha7);
  endtask

  task automatic summarize();
    $display("Compares %0d, mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    numErrors++;
    summarize();
  end

  initial begin
    busCfg = MBP_CFG_STD;
    addr16OnPortA = 1'b0;
    imcModeFlat = '0;
    imcUseTerm = 3'h0;
    outSelCfg = '0;
    resourceSel = 1'b0;
    regWrite = 1'b0;
    regPort = 2'h0;
    regKind = 2'h0;
    regWdata = 8'h00;
    rbSel = MBP_RB_DOUT;
    mcelOut = '0;
    chipSel = '0;
    oeTerm = '0;
    imcTerm = '0;
    pinIn = '0;
    testReset();
    testAddr();
    testStrobes();
    testPorts();
    testAd();
    testImc();
    testReset();
    summarize();
  end
endmodule
